// >>> design/change_detect.sv
// Change detector on a level of parameterised width, with a rising-edge detector on bit 0 only.
`timescale 1ns/10ps
module change_detect #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  change_event_if.detector ev
);
  logic [W-1:0] last_reg; // Level seen on the previous edge.

  // Hold the previous level; reset to zero so a level high out of reset counts as a rise.
  always_ff @(posedge clk) begin
    if (rst) begin
      last_reg <= '0;
    end else begin
      last_reg <= ev.level;
    end
  end

  // Combinational so the owner can register the event in the same cycle.
  assign ev.changed = (ev.level != last_reg);
  assign ev.rose = ev.level[0] & ~last_reg[0];
endmodule

// >>> design/change_event_if.sv
// Carrier between a watched level and its change detector.
`timescale 1ns/10ps
interface change_event_if #(parameter int W = 1);
  logic [W-1:0] level; // Level being watched.
  logic changed; // Any bit differs from last cycle.
  logic rose; // Bit 0 went from low to high.
  modport source (output level, input changed, input rose);
  modport detector (input level, output changed, output rose);
endinterface

// >>> design/sensor_misc_config_regs.sv
// Miscellaneous configuration register bank with halt, matrix command and sweep sequencing.
`timescale 1ns/10ps
`include "sensor_misc_config_regs.svh"
module sensor_misc_config_regs
  import sensor_misc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic lower_page_sel,
  input wire logic all_idle,
  output logic low_power_mode,
  input wire logic [7:0] wait_interval_setting,
  output logic [11:0] wait_interval_eff,
  input wire logic irq_pending,
  output logic osc_run,
  output logic irq_halt_flag,
  input wire logic switch_matrix_go,
  input wire logic sm_done,
  output logic sm_start,
  output logic [1:0] sm_cmd,
  output logic sm_busy,
  input wire logic [5:0] flicker_status,
  output logic sys_irq,
  input wire logic flicker_valid,
  input wire logic [15:0] flicker_sample,
  output logic flicker_wr,
  output logic [15:0] flicker_data,
  input wire logic meas_start,
  input wire logic cycle_done,
  output logic meas_busy,
  output logic meas_done,
  output logic [1:0] cycle_num,
  output logic [4:0] slot_base,
  output logic [1:0] clear_pd_sel
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register storage and access decode.

  logic idle_economy_reg; // Low power idle enable.
  logic page_select_reg; // 1 routes accesses to the lower page.
  logic wait_stretch_x16_reg; // Multiply wait interval by sixteen.
  logic halt_on_irq_enable_reg; // Stop oscillator while an interrupt is active.
  logic flicker_sys_irq_enable_reg; // System interrupt on flicker status change.
  logic matrix_done_irq_enable_reg; // System interrupt on matrix completion.
  logic flicker_byte_queue_mode_reg; // 8-bit flicker storage.
  sweep_e sweep_sel_reg; // Channel sweep select field.
  sm_cmd_e sm_cmd_field_reg; // Switch matrix command field.
  logic halt_flag_reg; // Interrupt halt flag.
  logic upper_ok; // Address lies in the upper page and that page is selected.
  logic [7:0] read_mux; // Read value before the output flop.

  // Whole-register reset words held as constants, so that single fields can be picked out.
  localparam logic [7:0] GEN_CFG_RST = `RESET_GENERAL_CONFIG;
  localparam logic [7:0] SYS_IRQ_EN_RST = `RESET_SYSTEM_IRQ_ENABLE;
  localparam logic [7:0] READOUT_RST = `RESET_READOUT_SEQUENCE;
  localparam logic [7:0] SM_CMD_RST = `RESET_SWITCH_MATRIX_CMD;

  // The general config register stays reachable from both pages; otherwise the page bit
  // could never be cleared once set.
  // page routing
  assign upper_ok = (reg_addr >= `PAGE_HIGH_BASE) && !page_select_reg;
  assign lower_page_sel = page_select_reg;

  // Configuration writes; only documented fields are stored, so reserved bits ignore writes.
  // reserved bits fixed
  always_ff @(posedge clk) begin
    if (rst) begin
      idle_economy_reg <= GEN_CFG_RST[`BIT_IDLE_ECONOMY];
      page_select_reg <= GEN_CFG_RST[`BIT_PAGE_SELECT];
      wait_stretch_x16_reg <= GEN_CFG_RST[`BIT_WAIT_STRETCH];
      halt_on_irq_enable_reg <= 1'b0;
      flicker_sys_irq_enable_reg <= SYS_IRQ_EN_RST[`BIT_FLICKER_IRQ_EN];
      matrix_done_irq_enable_reg <= SYS_IRQ_EN_RST[`BIT_MATRIX_DONE_IRQ_EN];
      flicker_byte_queue_mode_reg <= READOUT_RST[`BIT_BYTE_QUEUE];
      sweep_sel_reg <= sweep_e'(READOUT_RST[`SWEEP_MSB:`SWEEP_LSB]);
      sm_cmd_field_reg <= sm_cmd_e'(SM_CMD_RST[`CMD_MSB:`CMD_LSB]);
    end else if (reg_wr) begin
      if (reg_addr == `ADDR_GENERAL_CONFIG) begin
        idle_economy_reg <= reg_wdata[`BIT_IDLE_ECONOMY];
        page_select_reg <= reg_wdata[`BIT_PAGE_SELECT];
        wait_stretch_x16_reg <= reg_wdata[`BIT_WAIT_STRETCH];
      end else if (upper_ok) begin
        unique case (reg_addr)
          `ADDR_SLEEP_ON_IRQ_CONFIG: begin
            halt_on_irq_enable_reg <= reg_wdata[`BIT_HALT_ON_IRQ];
          end
          `ADDR_SYSTEM_IRQ_ENABLE_CONFIG: begin
            flicker_sys_irq_enable_reg <= reg_wdata[`BIT_FLICKER_IRQ_EN];
            matrix_done_irq_enable_reg <= reg_wdata[`BIT_MATRIX_DONE_IRQ_EN];
          end
          `ADDR_READOUT_SEQUENCE_CONFIG: begin
            flicker_byte_queue_mode_reg <= reg_wdata[`BIT_BYTE_QUEUE];
            sweep_sel_reg <= sweep_e'(reg_wdata[`SWEEP_MSB:`SWEEP_LSB]);
          end
          `ADDR_SWITCH_MATRIX_COMMAND_CONFIG: begin
            sm_cmd_field_reg <= sm_cmd_e'(reg_wdata[`CMD_MSB:`CMD_LSB]);
          end
          default: begin
            // Halt status writes are decoded with the halt flag; other upper-page offsets belong to blocks outside this bank.
          end
        endcase
      end
    end
  end

  // Read multiplexer; out-of-page and unknown offsets read zero.
  always_comb begin
    read_mux = 8'h00;
    if (reg_addr == `ADDR_GENERAL_CONFIG) begin
      read_mux[`BIT_IDLE_ECONOMY] = idle_economy_reg;
      read_mux[`BIT_PAGE_SELECT] = page_select_reg;
      read_mux[`BIT_WAIT_STRETCH] = wait_stretch_x16_reg;
    end else if (upper_ok) begin
      unique case (reg_addr)
        `ADDR_HALT_STATUS: read_mux[`BIT_IRQ_HALT_FLAG] = halt_flag_reg;
        `ADDR_SLEEP_ON_IRQ_CONFIG: begin
          read_mux[3:0] = `RESET_SLEEP_ON_IRQ_LOW;
          read_mux[`BIT_HALT_ON_IRQ] = halt_on_irq_enable_reg;
        end
        `ADDR_SYSTEM_IRQ_ENABLE_CONFIG: begin
          read_mux[`BIT_FLICKER_IRQ_EN] = flicker_sys_irq_enable_reg;
          read_mux[`BIT_MATRIX_DONE_IRQ_EN] = matrix_done_irq_enable_reg;
        end
        `ADDR_READOUT_SEQUENCE_CONFIG: begin
          read_mux[`BIT_BYTE_QUEUE] = flicker_byte_queue_mode_reg;
          read_mux[`SWEEP_MSB:`SWEEP_LSB] = sweep_sel_reg;
        end
        `ADDR_SWITCH_MATRIX_COMMAND_CONFIG: read_mux[`CMD_MSB:`CMD_LSB] = sm_cmd_field_reg;
        default: read_mux = 8'h00;
      endcase
    end
  end

  // Read data is registered and held until the next read.
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= read_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Power: idle economy, wait stretch and halt on interrupt.

  always_ff @(posedge clk) begin
    if (rst) begin
      low_power_mode <= 1'b0;
    end else begin
      low_power_mode <= idle_economy_reg && all_idle;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wait_interval_eff <= 12'h000;
    end else if (wait_stretch_x16_reg) begin
      wait_interval_eff <= {wait_interval_setting, 4'h0};
    end else begin
      wait_interval_eff <= {4'h0, wait_interval_setting};
    end
  end

  // Halt flag: set wins over the host's clear, and a clear while an interrupt is still
  // pending is ignored, so the oscillator never restarts into a live interrupt.
  // halt flag set
  always_ff @(posedge clk) begin
    if (rst) begin
      halt_flag_reg <= 1'b0;
    end else if (halt_on_irq_enable_reg && irq_pending) begin
      halt_flag_reg <= 1'b1;
    end else if (reg_wr && upper_ok && reg_addr == `ADDR_HALT_STATUS
                 && reg_wdata[`BIT_IRQ_HALT_FLAG] && !irq_pending) begin
      halt_flag_reg <= 1'b0;
    end
  end
  assign irq_halt_flag = halt_flag_reg;
  assign osc_run = !halt_flag_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Switch matrix command and system interrupt.

  change_event_if #(.W(1)) go_ev ();
  change_event_if #(.W(`FLICKER_STATUS_W)) fd_ev ();
  assign go_ev.level = switch_matrix_go;
  assign fd_ev.level = flicker_status;

  change_detect #(.W(1)) go_det (.clk(clk), .rst(rst), .ev(go_ev));
  change_detect #(.W(`FLICKER_STATUS_W)) fd_det (.clk(clk), .rst(rst), .ev(fd_ev));

  // Launch on the go bit's rising edge; the command is captured at launch, which also
  // shields the engine from a host that breaks the no-change-while-busy contract.
  // command on go
  always_ff @(posedge clk) begin
    if (rst) begin
      sm_start <= 1'b0;
      sm_busy <= 1'b0;
      sm_cmd <= 2'h0;
    end else begin
      sm_start <= 1'b0;
      if (go_ev.rose && !sm_busy && sm_cmd_field_reg != SM_RESERVED) begin
        sm_start <= 1'b1;
        sm_busy <= 1'b1;
        sm_cmd <= sm_cmd_field_reg;
      end else if (sm_done) begin
        sm_busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sys_irq <= 1'b0;
    end else begin
      sys_irq <= (flicker_sys_irq_enable_reg && fd_ev.changed)
                 || (matrix_done_irq_enable_reg && sm_done);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Flicker sample storage width.

  always_ff @(posedge clk) begin
    if (rst) begin
      flicker_wr <= 1'b0;
      flicker_data <= 16'h0000;
    end else begin
      flicker_wr <= flicker_valid;
      if (flicker_valid) begin
        if (!flicker_byte_queue_mode_reg) begin
          flicker_data <= flicker_sample;
        end else if (flicker_sample[15:8] != 8'h00) begin
          flicker_data <= {8'h00, `FLICKER_BYTE_MAX};
        end else begin
          flicker_data <= {8'h00, flicker_sample[7:0]};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Automatic channel sweep sequencer.

  seq_state_e seq_reg; // Current cycle of the measurement.
  sweep_e sweep_run_reg; // Sweep captured at start; later field writes do not disturb it.

  // Step through the cycles; the reserved sweep value runs as a single cycle.
  // six-channel sweep
  always_ff @(posedge clk) begin
    if (rst) begin
      seq_reg <= SEQ_IDLE;
      sweep_run_reg <= SWEEP_6;
      meas_done <= 1'b0;
    end else begin
      meas_done <= 1'b0;
      unique case (seq_reg)
        SEQ_IDLE: begin
          if (meas_start) begin
            seq_reg <= SEQ_CYCLE1;
            sweep_run_reg <= sweep_sel_reg;
          end
        end
        SEQ_CYCLE1: begin
          if (cycle_done) begin
            if (sweep_run_reg == SWEEP_12 || sweep_run_reg == SWEEP_18) begin
              seq_reg <= SEQ_CYCLE2;
            end else begin
              seq_reg <= SEQ_IDLE;
              meas_done <= 1'b1;
            end
          end
        end
        SEQ_CYCLE2: begin
          if (cycle_done) begin
            if (sweep_run_reg == SWEEP_18) begin
              seq_reg <= SEQ_CYCLE3;
            end else begin
              seq_reg <= SEQ_IDLE;
              meas_done <= 1'b1;
            end
          end
        end
        SEQ_CYCLE3: begin
          if (cycle_done) begin
            seq_reg <= SEQ_IDLE;
            meas_done <= 1'b1;
          end
        end
      endcase
    end
  end

  // Cycle number picks the photodiode group; slot base places results in the data slots.
  // data slot placement
  always_comb begin
    unique case (seq_reg)
      SEQ_CYCLE2: cycle_num = 2'h1;
      SEQ_CYCLE3: cycle_num = 2'h2;
      default: cycle_num = 2'h0;
    endcase
  end
  assign slot_base = (cycle_num == 2'h0) ? 5'h00
                   : (cycle_num == 2'h1) ? `SLOTS_PER_CYCLE : `SLOTS_PER_CYCLE + `SLOTS_PER_CYCLE;
  assign meas_busy = (seq_reg != SEQ_IDLE);
  assign clear_pd_sel = 2'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  chk_low_power: assert property (@(posedge clk) disable iff (rst)
    idle_economy_reg && all_idle |=> low_power_mode) else $error("low power not entered");
  chk_page_block: assert property (@(posedge clk) disable iff (rst)
    reg_rd && reg_addr >= `PAGE_LOW_BASE && reg_addr < `PAGE_HIGH_BASE && !page_select_reg
    |=> reg_rdata == 8'h00) else $error("lower page readable while deselected");
  chk_wait_stretch: assert property (@(posedge clk) disable iff (rst)
    wait_stretch_x16_reg |=> wait_interval_eff == {$past(wait_interval_setting), 4'h0})
    else $error("wait not stretched");
  chk_halt_sets: assert property (@(posedge clk) disable iff (rst)
    halt_on_irq_enable_reg && irq_pending |=> irq_halt_flag && !osc_run)
    else $error("halt not entered");
  chk_halt_holds: assert property (@(posedge clk) disable iff (rst)
    irq_halt_flag && irq_pending |=> irq_halt_flag) else $error("restart with pending irq");
  chk_sm_launch: assert property (@(posedge clk) disable iff (rst)
    go_ev.rose && !sm_busy && sm_cmd_field_reg != SM_RESERVED
    |=> sm_start && sm_cmd == $past(sm_cmd_field_reg)) else $error("matrix command not launched");
  chk_sm_reserved: assert property (@(posedge clk) disable iff (rst)
    sm_cmd_field_reg == SM_RESERVED && !sm_busy |=> !sm_start) else $error("reserved launched");
  chk_done_irq: assert property (@(posedge clk) disable iff (rst)
    matrix_done_irq_enable_reg && sm_done |=> sys_irq) else $error("done irq missing");
  chk_fd_irq: assert property (@(posedge clk) disable iff (rst)
    flicker_sys_irq_enable_reg && fd_ev.changed |=> sys_irq) else $error("flicker irq missing");
  chk_byte_clamp: assert property (@(posedge clk) disable iff (rst)
    flicker_valid && flicker_byte_queue_mode_reg && flicker_sample > 16'h00FF
    |=> flicker_data == 16'h00FF) else $error("flicker sample not clamped");
  chk_six_done: assert property (@(posedge clk) disable iff (rst)
    seq_reg == SEQ_CYCLE1 && cycle_done && sweep_run_reg == SWEEP_6
    |=> meas_done && !meas_busy) else $error("six channel sweep overran");
  chk_eighteen: assert property (@(posedge clk) disable iff (rst)
    seq_reg == SEQ_CYCLE2 && cycle_done && sweep_run_reg == SWEEP_18
    |=> seq_reg == SEQ_CYCLE3 && slot_base == 5'h0C) else $error("third cycle skipped");

  cov_halt: cover property (@(posedge clk) disable iff (rst) $rose(irq_halt_flag));
  cov_restart: cover property (@(posedge clk) disable iff (rst) $fell(irq_halt_flag));
  cov_sweep18: cover property (@(posedge clk) disable iff (rst)
    meas_done && sweep_run_reg == SWEEP_18);
  cov_sm_start: cover property (@(posedge clk) disable iff (rst) sm_start);

endmodule

// >>> design/sensor_misc_config_regs.svh
// Register offsets, field positions, reset values and counts for the misc configuration bank.
`ifndef SENSOR_MISC_CONFIG_REGS_SVH
`define SENSOR_MISC_CONFIG_REGS_SVH

// Register offsets in the upper page.
`define ADDR_GENERAL_CONFIG 8'hBF
`define ADDR_HALT_STATUS 8'hBC
`define ADDR_SLEEP_ON_IRQ_CONFIG 8'hC7
`define ADDR_SYSTEM_IRQ_ENABLE_CONFIG 8'hCA
`define ADDR_READOUT_SEQUENCE_CONFIG 8'hD6
`define ADDR_SWITCH_MATRIX_COMMAND_CONFIG 8'hF5

// Page boundaries.
`define PAGE_HIGH_BASE 8'h80
`define PAGE_LOW_BASE 8'h20

// Field positions.
`define BIT_IDLE_ECONOMY 5
`define BIT_PAGE_SELECT 4
`define BIT_WAIT_STRETCH 2
`define BIT_HALT_ON_IRQ 4
`define BIT_IRQ_HALT_FLAG 1
`define BIT_FLICKER_IRQ_EN 6
`define BIT_MATRIX_DONE_IRQ_EN 4
`define BIT_BYTE_QUEUE 7
`define SWEEP_MSB 6
`define SWEEP_LSB 5
`define CMD_MSB 4
`define CMD_LSB 3

// Reset values.
`define RESET_GENERAL_CONFIG 8'h00
`define RESET_SLEEP_ON_IRQ_LOW 4'hC
`define RESET_SYSTEM_IRQ_ENABLE 8'h00
`define RESET_READOUT_SEQUENCE 8'h00
`define RESET_SWITCH_MATRIX_CMD 8'h00

// Counts.
`define WAIT_STRETCH_SHIFT 4
`define FLICKER_BYTE_MAX 8'hFF
`define SLOTS_PER_CYCLE 5'h06
`define FLICKER_STATUS_W 6

`endif

// >>> design/sensor_misc_pkg.sv
// Types shared by the misc configuration bank modules.
package sensor_misc_pkg;

  // Switch matrix command codes.
  typedef enum logic [1:0] {
    SM_INIT_FROM_ROM = 2'h0,
    SM_READ_TO_RAM = 2'h1,
    SM_WRITE_FROM_RAM = 2'h2,
    SM_RESERVED = 2'h3
  } sm_cmd_e;

  // Channel sweep selections.
  typedef enum logic [1:0] {
    SWEEP_6 = 2'h0,
    SWEEP_RESERVED = 2'h1,
    SWEEP_12 = 2'h2,
    SWEEP_18 = 2'h3
  } sweep_e;

  // Measurement sequencer states.
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_CYCLE1,
    SEQ_CYCLE2,
    SEQ_CYCLE3
  } seq_state_e;

endpackage

// >>> verification/host_model.sv
// Host-side model that reaches the configuration bank one byte at a time.
`timescale 1ns/10ps
`include "sensor_misc_config_regs.svh"
module host_model (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  // The port idles with both strobes low from time zero.
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end

  // Called at a falling edge; the strobe spans exactly one rising edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    // Released data is inverted so a stale value can never pass unseen.
    reg_wdata = ~d;
    // One idle edge, so a following write never lowers and raises the strobe at once.
    @(negedge clk);
  endtask

  // Read data is registered, so it is taken one edge after the strobe.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    d = reg_rdata;
    // One idle edge between back-to-back reads.
    @(negedge clk);
  endtask

  // host clears halt
  // Clearing only works once every interrupt has been dropped by the host.
  task automatic clear_halt();
    wr(`ADDR_HALT_STATUS, 8'h02);
  endtask
endmodule

// >>> verification/sensor_misc_config_regs_tb_top.sv
// Self-checking testbench for the misc configuration register bank.
`timescale 1ns/10ps
`include "sensor_misc_config_regs.svh"
module sensor_misc_config_regs_tb_top;
  logic clk = 1'b0, rst = 1'b1, all_idle = 1'b0, irq_pending = 1'b0, go = 1'b0;
  logic sm_done = 1'b0, fl_valid = 1'b0, meas_start = 1'b0, cycle_done = 1'b0;
  logic [7:0] wait_set = 8'hAB, rd_val;
  logic [5:0] fl_status = 6'h00;
  logic [15:0] fl_sample = 16'h0000;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, page, lpm, osc_run, halt, sm_start, sm_busy, sys_irq, fl_wr;
  logic meas_busy, meas_done;
  logic [11:0] wait_eff;
  logic [1:0] sm_cmd, cyc, pd_sel;
  logic [4:0] base;
  logic [15:0] fl_data;
  int miscompares = 0, check_count = 0;
  logic [7:0] zero_regs [4] = '{8'hCA, 8'hD6, 8'hF5, 8'hC0}; // Offsets that read zero at reset.
  // Pulse outputs gathered so one task can look for any of them.
  wire [3:0] pulses = {meas_done, fl_wr, sys_irq, sm_start};

  always #2.5 clk = ~clk;

  host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  sensor_misc_config_regs dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lower_page_sel(page),
    .all_idle(all_idle), .low_power_mode(lpm), .wait_interval_setting(wait_set),
    .wait_interval_eff(wait_eff), .irq_pending(irq_pending), .osc_run(osc_run),
    .irq_halt_flag(halt), .switch_matrix_go(go), .sm_done(sm_done), .sm_start(sm_start),
    .sm_cmd(sm_cmd), .sm_busy(sm_busy), .flicker_status(fl_status), .sys_irq(sys_irq),
    .flicker_valid(fl_valid), .flicker_sample(fl_sample), .flicker_wr(fl_wr),
    .flicker_data(fl_data), .meas_start(meas_start), .cycle_done(cycle_done),
    .meas_busy(meas_busy), .meas_done(meas_done), .cycle_num(cyc), .slot_base(base),
    .clear_pd_sel(pd_sel));

  ////////////////////////////////////////////////////////////////////////////
  // Value comparison; case equality keeps an unknown from matching.
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Looks now and up to three more falling edges for a pulse, or its absence.
  task automatic pulse(input int idx, input logic exp, input string name);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 4 && !hit; i++) begin
      if (pulses[idx] === 1'b1) hit = 1'b1;
      else @(negedge clk);
    end
    check(name, {15'h0, exp}, {15'h0, hit});
  endtask

  // Register read compared against a value worked out here.
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, rd_val);
    check("reg_rdata", {8'h00, exp}, {8'h00, rd_val});
  endtask

  // One-cycle input pulse launched at a falling edge.
  task automatic strobe(input int which);
    case (which)
      0: sm_done = 1'b1;
      1: fl_valid = 1'b1;
      2: meas_start = 1'b1;
      default: cycle_done = 1'b1;
    endcase
    @(negedge clk);
    // Only the raised strobe is lowered, so another may be raised in this same step.
    case (which)
      0: sm_done = 1'b0;
      1: fl_valid = 1'b0;
      2: meas_start = 1'b0;
      default: cycle_done = 1'b0;
    endcase
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // A hang is cut short well beyond the roughly 130 cycles the tests need.
  initial begin
    #(5 * 5000);
    miscompares++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    // Reset values and reserved bits.
    rchk(`ADDR_GENERAL_CONFIG, 8'h00);
    rchk(`ADDR_SLEEP_ON_IRQ_CONFIG, 8'h0C);
    foreach (zero_regs[i]) begin
      rchk(zero_regs[i], 8'h00);
    end
    check("clear_pd_sel", 16'h0, {14'h0, pd_sel});
    check("wait_eff", 16'h00AB, {4'h0, wait_eff});
    // Economy, page and stretch bits set; reserved bits written but ignored.
    host.wr(`ADDR_GENERAL_CONFIG, 8'hFF);
    all_idle = 1'b1;
    repeat (2) @(negedge clk);
    check("low_power", 16'h1, {15'h0, lpm});
    check("wait_eff", 16'h0AB0, {4'h0, wait_eff});
    check("page_sel", 16'h1, {15'h0, page});
    rchk(`ADDR_GENERAL_CONFIG, 8'h34);
    host.wr(`ADDR_SLEEP_ON_IRQ_CONFIG, 8'h10);
    rchk(`ADDR_SLEEP_ON_IRQ_CONFIG, 8'h00);
    all_idle = 1'b0;
    host.wr(`ADDR_GENERAL_CONFIG, 8'h00);
    @(negedge clk);
    check("low_power", 16'h0, {15'h0, lpm});
    check("page_sel", 16'h0, {15'h0, page});
    rchk(`ADDR_SLEEP_ON_IRQ_CONFIG, 8'h0C);
    // Halt on interrupt; a clear while an interrupt is pending is lost.
    host.wr(`ADDR_SLEEP_ON_IRQ_CONFIG, 8'h10);
    rchk(`ADDR_SLEEP_ON_IRQ_CONFIG, 8'h1C);
    irq_pending = 1'b1;
    repeat (2) @(negedge clk);
    check("halt_osc", 16'h10, {11'h0, halt, 3'h0, osc_run});
    host.clear_halt();
    @(negedge clk);
    check("halt_flag", 16'h1, {15'h0, halt});
    host.rd(`ADDR_HALT_STATUS, rd_val);
    check("halt_read", 16'h1, {15'h0, rd_val[1]});
    irq_pending = 1'b0;
    host.clear_halt();
    @(negedge clk);
    check("halt_osc", 16'h01, {11'h0, halt, 3'h0, osc_run});
    // Matrix commands, each completion raising a system interrupt.
    host.wr(`ADDR_SYSTEM_IRQ_ENABLE_CONFIG, 8'h50);
    for (int c = 0; c < 4; c++) begin
      host.wr(`ADDR_SWITCH_MATRIX_COMMAND_CONFIG, 8'(c << 3));
      go = 1'b1;
      @(negedge clk);
      pulse(0, c != 3, "sm_start");
      if (c != 3) begin
        check("sm_cmd_busy", 16'(c * 2 + 1), {13'h0, sm_cmd, sm_busy});
        strobe(0);
        pulse(1, 1'b1, "sys_irq_sm");
        check("sm_busy", 16'h0, {15'h0, sm_busy});
      end
      go = 1'b0;
      @(negedge clk);
    end
    // Flicker status change, enabled and then masked.
    fl_status = 6'h01;
    pulse(1, 1'b1, "sys_irq_fd");
    host.wr(`ADDR_SYSTEM_IRQ_ENABLE_CONFIG, 8'h10);
    fl_status = 6'h03;
    pulse(1, 1'b0, "sys_irq_fd");
    // Flicker samples, raw and in byte mode with clamping.
    for (int m = 0; m < 3; m++) begin
      host.wr(`ADDR_READOUT_SEQUENCE_CONFIG, m == 0 ? 8'h00 : 8'h80);
      fl_sample = (m == 2) ? 16'h0045 : 16'h0123;
      strobe(1);
      pulse(2, 1'b1, "flicker_wr");
      check("flicker_data", m == 0 ? 16'h0123 : (m == 1 ? 16'h00FF : 16'h0045), fl_data);
    end
    // Every sweep value, stepping each cycle through its data slots.
    for (int v = 0; v < 4; v++) begin
      host.wr(`ADDR_READOUT_SEQUENCE_CONFIG, 8'(v << 5));
      strobe(2);
      for (int k = 0; k < (v < 2 ? 1 : v); k++) begin
        // A spare edge keeps cycle_done from being lowered and raised in one step.
        if (k > 0) begin
          @(negedge clk);
        end
        check("busy_cycle", 16'(k + 4), {13'h0, meas_busy, cyc});
        check("slot_base", 16'(k * 6), {11'h0, base});
        strobe(3);
      end
      pulse(3, 1'b1, "meas_done");
      @(negedge clk);
      check("meas_busy", 16'h0, {15'h0, meas_busy});
    end
    test_done();
  end
endmodule
